// File: core/rsst_defs.svh
`ifndef RSST_DEFS_SVH
`define RSST_DEFS_SVH

// ==========================================================
// register offsets (byte addresses on the apb bus)
`define RSST_ADDR_CTRL 8'h00
`define RSST_ADDR_DELAY 8'h04
`define RSST_ADDR_STATUS 8'h08
`define RSST_ADDR_MASK 8'h0c
`define RSST_ADDR_ZCAP 8'h10
`define RSST_ADDR_DCAP 8'h14
`define RSST_ADDR_STATE 8'h18

// ==========================================================
// field positions
`define RSST_CTRL_W 9
`define RSST_ST_ZC 0
`define RSST_ST_DM 1
`define RSST_ST_RDY 2
`define RSST_ST_W 3
`define RSST_STATE_HST 0
`define RSST_STATE_RDY 1

// ==========================================================
// reset values
`define RSST_CTRL_RST 9'h000
`define RSST_DELAY_RST 8'h00
`define RSST_STATUS_RST 3'h0
`define RSST_MASK_RST 3'h0
`define RSST_CAP_RST 16'h0000

// ==========================================================
// sampling mode codes in the control register, and the threshold select code that writes ignore
`define RSST_MODE_OFFTIME 3'h0
`define RSST_MODE_ONDELAY 3'h1
`define RSST_MODE_SCF 3'h2
`define RSST_MODE_ONSCF 3'h3
`define RSST_MODE_TACHO 3'h4
`define RSST_VREF_BAD 3'h7

// ==========================================================
// timing
`define RSST_CLK_MHZ 10
`define RSST_STARTUP_NS 3000
`define RSST_STARTUP_CYC ((`RSST_STARTUP_NS * `RSST_CLK_MHZ + 999) / 1000)

`endif

// File: core/rsst_pkg.sv
// ==========================================================
// shared types of the rotor sense sampling block
package rsst_pkg;

  // one-hot sampling modes
  typedef enum logic [4:0] {
    RSST_M_OFFTIME = 5'h01,
    RSST_M_ONDELAY = 5'h02,
    RSST_M_SCF = 5'h04,
    RSST_M_ONSCF = 5'h08,
    RSST_M_TACHO = 5'h10
  } rsst_mode_type;

  // control register layout, msb first
  typedef struct packed {
    logic demag_sel;
    logic [2:0] ref_threshold_select;
    logic [2:0] mode;
    logic dac_en;
    logic comp_clk_en;
  } rsst_ctrl_type;

endpackage : rsst_pkg

// File: core/rsst_sampler.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "rsst_defs.svh"

// Functional notes
// - after comparator clock or dac enable, wait 3 us start-up before sampling
// - tachogenerator mode captures on the fourth clock after the input toggles
// - off-time sampling captures timer into zero-cross register 3 clocks after phase on
// - off-time sampling updates sampled state one clock after phase output on
// - sampling-clock mode raises zero-cross one sample period plus 3 clocks after toggle
// - demag event captures timer one sample period plus 3 clocks after toggle
// - on-time delayed sampling updates sampled state after delay plus one clock
// - on-time delayed sampling raises zero-cross after delay plus three clocks
// - on-time delay at sampling clock: delay plus sample period plus 3 clocks
// - 3-bit threshold field selects reference, codes 000 to 110 valid
// - detection moment may jitter by one clock or one sampling-clock period

module rsst_sampler
  import rsst_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic rotor_sense_input,
  input wire logic sampling_clock,
  input wire logic phase_pwm_output,
  input wire logic [15:0] motor_timer,
  output logic comp_clk_en_ff,
  output logic dac_en_ff,
  output logic [2:0] ref_threshold_select_ff,
  output logic zc_event_ff,
  output logic dm_event_ff,
  output logic irq_ff
);

  // ==========================================================
  // declarations
  rsst_ctrl_type ctrl_ff;
  logic [7:0] sampling_delay_select_ff;
  logic [`RSST_ST_W-1:0] status_ff;
  logic [`RSST_ST_W-1:0] mask_ff;
  logic [`RSST_ST_W-1:0] nxt_status;
  logic [`RSST_ST_W-1:0] st_set;
  logic [`RSST_ST_W-1:0] st_clr;
  logic [15:0] zero_cross_capture_reg_ff;
  logic [15:0] demag_capture_reg_ff;
  logic cmp_s1_ff;
  logic cmp_s2_ff;
  logic scf_s1_ff;
  logic scf_s2_ff;
  logic scf_prev_ff;
  logic pwm_prev_ff;
  logic [5:0] su_cnt_ff;
  logic ready_ff;
  logic [7:0] dcnt_ff;
  logic arm_ff;
  logic sampled_comparator_state_ff;
  logic [1:0] sh_ff;
  rsst_mode_type mode;
  logic comp_on;
  logic scf_tick;
  logic pwm_rise;
  logic pwm_fall;
  logic delay_done;
  logic sample_go;
  logic toggle;
  logic cap_go;
  logic access;
  logic wr_en;
  logic hit;
  logic [31:0] rd_val;

  // ==========================================================
  // input conditioning
  // comparator output: two flops, only the second is read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else if (ce) begin
      cmp_s1_ff <= rotor_sense_input;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // sampling clock taken as a plain input: sync, then rising edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      scf_s1_ff <= 1'b0;
      scf_s2_ff <= 1'b0;
      scf_prev_ff <= 1'b0;
    end else if (ce) begin
      scf_s1_ff <= sampling_clock;
      scf_s2_ff <= scf_s1_ff;
      scf_prev_ff <= scf_s2_ff;
    end
  end

  // phase output comes from logic on this clock, edge only
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pwm_prev_ff <= 1'b0;
    end else if (ce) begin
      pwm_prev_ff <= phase_pwm_output;
    end
  end

  assign scf_tick = scf_s2_ff & ~scf_prev_ff;
  assign pwm_rise = phase_pwm_output & ~pwm_prev_ff;
  assign pwm_fall = ~phase_pwm_output & pwm_prev_ff;

  // ==========================================================
  // mode decode, unknown codes fall back to off-time sampling
  always_comb begin
    case (ctrl_ff.mode)
      `RSST_MODE_ONDELAY: mode = RSST_M_ONDELAY;
      `RSST_MODE_SCF: mode = RSST_M_SCF;
      `RSST_MODE_ONSCF: mode = RSST_M_ONSCF;
      `RSST_MODE_TACHO: mode = RSST_M_TACHO;
      default: mode = RSST_M_OFFTIME;
    endcase
  end

  // ==========================================================
  // start-up filter: no sampling until the comparator settled
  assign comp_on = ctrl_ff.comp_clk_en | ctrl_ff.dac_en;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      su_cnt_ff <= 6'h00;
      ready_ff <= 1'b0;
    end else if (ce) begin
      if (!comp_on) begin
        su_cnt_ff <= 6'h00;
        ready_ff <= 1'b0;
      end else if (!ready_ff) begin
        su_cnt_ff <= su_cnt_ff + 6'h01;
        ready_ff <= (su_cnt_ff == 6'(`RSST_STARTUP_CYC - 1));
      end
    end
  end

  // ==========================================================
  // on-time delay counter, restarted by every phase turn-on in the two on-time modes
  assign delay_done = (sampling_delay_select_ff == 8'h00) ? pwm_rise : (dcnt_ff == 8'h01);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      dcnt_ff <= 8'h00;
    end else if (ce) begin
      if (pwm_fall) begin
        dcnt_ff <= 8'h00;
      end else if (pwm_rise && (mode == RSST_M_ONDELAY || mode == RSST_M_ONSCF)) begin
        dcnt_ff <= sampling_delay_select_ff;
      end else if (dcnt_ff != 8'h00) begin
        dcnt_ff <= dcnt_ff - 8'h01;
      end
    end
  end

  // after the delay, wait for the next sampling clock edge
  always_ff @(posedge clock) begin
    if (!nrst) begin
      arm_ff <= 1'b0;
    end else if (ce) begin
      if (pwm_fall || mode != RSST_M_ONSCF) begin
        arm_ff <= 1'b0;
      end else if (delay_done) begin
        arm_ff <= 1'b1;
      end else if (scf_tick) begin
        arm_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sample strobe per mode, gated by the start-up filter
  always_comb begin
    sample_go = 1'b0;
    if (ready_ff) begin
      case (mode)
        RSST_M_OFFTIME: sample_go = pwm_rise;
        RSST_M_ONDELAY: sample_go = delay_done;
        RSST_M_SCF: sample_go = scf_tick;
        RSST_M_ONSCF: sample_go = arm_ff & scf_tick;
        RSST_M_TACHO: sample_go = 1'b1;
        default: sample_go = 1'b0;
      endcase
    end
  end

  assign toggle = sample_go & (cmp_s2_ff != sampled_comparator_state_ff);

  // sampled state bit, one clock after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sampled_comparator_state_ff <= 1'b0;
    end else if (ce) begin
      if (sample_go) begin
        sampled_comparator_state_ff <= cmp_s2_ff;
      end
    end
  end

  // event pipeline; flushed while the comparator is off
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sh_ff <= 2'b00;
    end else if (ce) begin
      if (!ready_ff) begin
        sh_ff <= 2'b00;
      end else begin
        sh_ff <= {sh_ff[0], toggle};
      end
    end
  end

  // tacho counts from the pin: two sync flops plus two stages
  assign cap_go = (mode == RSST_M_TACHO) ? sh_ff[0] : sh_ff[1];

  // ==========================================================
  // timer captures and event pulses
  always_ff @(posedge clock) begin
    if (!nrst) begin
      zero_cross_capture_reg_ff <= `RSST_CAP_RST;
      demag_capture_reg_ff <= `RSST_CAP_RST;
      zc_event_ff <= 1'b0;
      dm_event_ff <= 1'b0;
    end else if (ce) begin
      zc_event_ff <= cap_go & ~ctrl_ff.demag_sel;
      dm_event_ff <= cap_go & ctrl_ff.demag_sel;
      if (cap_go && ctrl_ff.demag_sel) begin
        demag_capture_reg_ff <= motor_timer;
      end else if (cap_go) begin
        zero_cross_capture_reg_ff <= motor_timer;
      end
    end
  end

  // ==========================================================
  // apb slave: one wait state, then answer
  assign access = psel & penable;
  assign wr_en = access & pwrite & pready_ff;

  // read mux and address decode
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `RSST_ADDR_CTRL: rd_val = 32'(ctrl_ff);
      `RSST_ADDR_DELAY: rd_val = 32'(sampling_delay_select_ff);
      `RSST_ADDR_STATUS: rd_val = 32'(status_ff);
      `RSST_ADDR_MASK: rd_val = 32'(mask_ff);
      `RSST_ADDR_ZCAP: rd_val = 32'(zero_cross_capture_reg_ff);
      `RSST_ADDR_DCAP: rd_val = 32'(demag_capture_reg_ff);
      `RSST_ADDR_STATE: rd_val = 32'({ready_ff, sampled_comparator_state_ff});
      default: hit = 1'b0;
    endcase
  end

  // handshake and read data
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= access & ~pready_ff;
      pslverr_ff <= access & ~pready_ff & ~hit;
      if (access && !pready_ff && !pwrite) begin
        prdata_ff <= rd_val;
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // control, delay and mask registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_ff <= rsst_ctrl_type'(`RSST_CTRL_RST);
      sampling_delay_select_ff <= `RSST_DELAY_RST;
      mask_ff <= `RSST_MASK_RST;
    end else if (ce) begin
      if (wr_en && paddr == `RSST_ADDR_CTRL) begin
        ctrl_ff.demag_sel <= pwdata[8];
        ctrl_ff.mode <= pwdata[4:2];
        ctrl_ff.dac_en <= pwdata[1];
        ctrl_ff.comp_clk_en <= pwdata[0];
        if (pwdata[7:5] != `RSST_VREF_BAD) begin
          ctrl_ff.ref_threshold_select <= pwdata[7:5];
        end
      end
      if (wr_en && paddr == `RSST_ADDR_DELAY) begin
        sampling_delay_select_ff <= pwdata[7:0];
      end
      if (wr_en && paddr == `RSST_ADDR_MASK) begin
        mask_ff <= pwdata[`RSST_ST_W-1:0];
      end
    end
  end

  // ==========================================================
  // sticky status, write one to clear, a set in the same cycle wins
  // ready event only in the cycle the filter expires, so software can clear it
  assign st_set = {comp_on & ~ready_ff & (su_cnt_ff == 6'(`RSST_STARTUP_CYC - 1)),
                   cap_go & ctrl_ff.demag_sel, cap_go & ~ctrl_ff.demag_sel};
  assign st_clr = (wr_en && paddr == `RSST_ADDR_STATUS) ? pwdata[`RSST_ST_W-1:0] :
                  {`RSST_ST_W{1'b0}};
  assign nxt_status = (status_ff & ~st_clr) | st_set;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      status_ff <= `RSST_STATUS_RST;
    end else if (ce) begin
      status_ff <= nxt_status;
    end
  end

  // ==========================================================
  // analog controls and interrupt line
  always_ff @(posedge clock) begin
    if (!nrst) begin
      comp_clk_en_ff <= 1'b0;
      dac_en_ff <= 1'b0;
      ref_threshold_select_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else if (ce) begin
      comp_clk_en_ff <= ctrl_ff.comp_clk_en;
      dac_en_ff <= ctrl_ff.dac_en;
      ref_threshold_select_ff <= ctrl_ff.ref_threshold_select;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

endmodule : rsst_sampler

// File: sim/rsst_chk.sv
`timescale 1ns/1ps
`include "rsst_defs.svh"
// ==========
// timing checker
module rsst_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic rotor_sense_input,
  input wire logic phase_pwm_output,
  input wire logic comp_clk_en_ff,
  input wire logic dac_en_ff,
  input wire logic [2:0] ref_threshold_select_ff,
  input wire logic zc_event_ff,
  input wire logic dm_event_ff,
  input wire logic irq_ff
);
  logic [2:0] mode_ff;
  logic [7:0] dly_ff;
  logic [9:0] pc_ff;
  logic [9:0] en_ff;
  logic dm_ff;
  logic mzc_ff;
  logic ph_ff;
  logic wr;
  logic ev;
  assign wr = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign ev = zc_event_ff || dm_event_ff;
  // shadow of written settings, cycles since phase on and since enable
  always_ff @(posedge clock) begin
    if (!nrst) begin
      {mode_ff, dly_ff, dm_ff, mzc_ff, ph_ff} <= 14'h0000;
      pc_ff <= 10'h000;
      en_ff <= 10'h000;
    end else begin
      ph_ff <= phase_pwm_output;
      if (wr && paddr == `RSST_ADDR_CTRL) {dm_ff, mode_ff} <= {pwdata[8], pwdata[4:2]};
      if (wr && paddr == `RSST_ADDR_DELAY) dly_ff <= pwdata[7:0];
      if (wr && paddr == `RSST_ADDR_MASK) mzc_ff <= pwdata[0];
      if (phase_pwm_output && !ph_ff) pc_ff <= 10'h001;
      else if (pc_ff != 10'h3ff) pc_ff <= pc_ff + 10'h001;
      if (!(comp_clk_en_ff || dac_en_ff)) en_ff <= 10'h000;
      else if (en_ff != 10'h3ff) en_ff <= en_ff + 10'h001;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_APB_WAIT: assert property (psel && !penable |=> !pready_ff ##1 pready_ff)
    else $error("apb answer not after one wait state");
  AST_APB_ERR: assert property (pslverr_ff |-> pready_ff &&
    (paddr[1:0] != 2'h0 || paddr > `RSST_ADDR_STATE))
    else $error("error answer on a mapped address");
  AST_ROUTE: assert property (ev |-> dm_event_ff == dm_ff && !(zc_event_ff && dm_event_ff))
    else $error("event routed to wrong capture");
  AST_PHASE_CAP: assert property (ev && (mode_ff < 3'h2 || mode_ff > 3'h4)
    |-> pc_ff == ((mode_ff == 3'h1 && dly_ff != 8'h00) ? 10'(dly_ff) + 10'h003 : 10'h003))
    else $error("capture not at phase on plus delay plus three");
  AST_IRQ: assert property (zc_event_ff && mzc_ff |=> irq_ff)
    else $error("unmasked event gave no interrupt");
  AST_STARTUP: assert property (ev |-> en_ff >= 10'h01e)
    else $error("event before start-up wait");
  AST_THRESH: assert property (wr && paddr == `RSST_ADDR_CTRL |-> ##2
    ref_threshold_select_ff == ($past(pwdata[7:5], 2) == 3'h7 ?
    $past(ref_threshold_select_ff, 2) : $past(pwdata[7:5], 2)))
    else $error("threshold select wrong after write");
  AST_TACHO: assert property (ev && mode_ff == 3'h4
    |-> $past(rotor_sense_input, 3) != $past(rotor_sense_input, 6))
    else $error("tacho capture not four cycles after toggle");
endmodule : rsst_chk

bind rsst_sampler rsst_chk i_chk (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .rotor_sense_input(rotor_sense_input),
  .phase_pwm_output(phase_pwm_output), .comp_clk_en_ff(comp_clk_en_ff),
  .dac_en_ff(dac_en_ff), .ref_threshold_select_ff(ref_threshold_select_ff),
  .zc_event_ff(zc_event_ff), .dm_event_ff(dm_event_ff), .irq_ff(irq_ff));

// File: sim/rsst_partner.sv
`timescale 1ns/1ps
// ==========
// comparator, inverter phase and motor timer around the sampler
module rsst_partner (
  input wire logic clock,
  input wire logic nrst,
  input wire logic comp_req,
  input wire logic phase_req,
  output wire logic rotor_sense_input,
  output wire logic sampling_clock,
  output logic phase_pwm_output,
  output logic [15:0] motor_timer
);
  logic [2:0] div_ff;
  // comparator settles after a propagation delay unrelated to the clock
  assign #37 rotor_sense_input = comp_req;
  assign sampling_clock = div_ff[2];
  // timer, sampling divider and phase output share the clock
  always_ff @(posedge clock) begin
    if (!nrst) begin
      div_ff <= 3'h0;
      motor_timer <= 16'h0000;
      phase_pwm_output <= 1'b0;
    end else begin
      div_ff <= div_ff + 3'h1;
      motor_timer <= motor_timer + 16'h0001;
      phase_pwm_output <= phase_req;
    end
  end
endmodule : rsst_partner

// File: sim/rotor_sense_sampling_timing_bench.sv
`timescale 1ns/1ps
`include "rsst_defs.svh"
// ==========
// self-checking bench of the sampler
module rotor_sense_sampling_timing_bench import rsst_pkg::*; ;
  logic clock, nrst, psel, penable, pwrite, comp_req, phase_req;
  logic pready_ff, pslverr_ff, rsi, scf, phase, cke, dac, zc, dm, irq, ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_ff, rs;
  logic [2:0] thr;
  logic [15:0] tmr, t1, cap;
  logic [32:0] expq[$];
  int bad_count = 0, samples_checked = 0, n, d;
  rsst_sampler i_dut (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .rotor_sense_input(rsi), .sampling_clock(scf), .phase_pwm_output(phase),
    .motor_timer(tmr), .comp_clk_en_ff(cke), .dac_en_ff(dac), .ref_threshold_select_ff(thr),
    .zc_event_ff(zc), .dm_event_ff(dm), .irq_ff(irq));
  rsst_partner i_part (.clock(clock), .nrst(nrst), .comp_req(comp_req),
    .phase_req(phase_req), .rotor_sense_input(rsi), .sampling_clock(scf),
    .phase_pwm_output(phase), .motor_timer(tmr));
  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function automatic logic [31:0] ctl(logic m, logic [2:0] t, logic [2:0] md, logic e);
    rsst_ctrl_type c;
    c = '{m, t, md, 1'b0, e};
    return {23'h000000, c};
  endfunction : ctl
  task automatic conclude();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(string s, logic [32:0] seen, logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
    int k;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready_ff !== 1'b1 && k < 20);
    {psel, penable} <= 2'h0;
    // one idle edge so the next call never re-drives psel in this time step
    @(posedge clock);
    if (k >= 20) begin
      bad_count++;
      conclude();
    end
  endtask : apb
  task automatic rd(logic [7:0] a, logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wev();
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (zc !== 1'b1 && dm !== 1'b1 && n < 300);
    cap = t1;
    if (n >= 300) begin
      bad_count++;
      conclude();
    end
  endtask : wev
  task automatic inr(string s, int lo, int hi);
    chk(s, {32'h0, n >= lo && n <= hi}, 33'h1);
  endtask : inr
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // read data compared against the oldest expectation
  always @(posedge clock) begin
    t1 <= tmr;
    if (psel && penable && pready_ff === 1'b1 && !pwrite && expq.size() > 0)
      chk($sformatf("reg %h", paddr), {pslverr_ff, prdata_ff}, expq.pop_front());
  end
  // ==========
  // scenarios
  initial begin
    {nrst, psel, penable, pwrite, comp_req, phase_req} = 6'h00;
    ce = 1'b1;
    {paddr, pwdata, rs} = {8'h00, 32'h0, 32'h00007075};
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 32; a += 4) rd(8'(a), {a == 28, 32'h0});
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `RSST_ADDR_CTRL, (rnd() & 32'hfffffe00) | ctl(0, 3'(c), 0, 0));
      rd(`RSST_ADDR_CTRL, {1'b0, ctl(0, (c == 7) ? 3'h6 : 3'(c), 0, 0)});
    end
    $display("test threshold codes done");
    apb(1'b1, `RSST_ADDR_CTRL, ctl(0, 3'h2, 3'h0, 1));
    apb(1'b1, `RSST_ADDR_MASK, 32'h1);
    repeat (18) @(posedge clock);
    rd(`RSST_ADDR_STATE, 33'h0);
    repeat (12) @(posedge clock);
    rd(`RSST_ADDR_STATE, 33'h2);
    $display("test start-up wait done");
    comp_req <= 1'b1;
    repeat (10) @(posedge clock);
    phase_req <= 1'b1;
    wev();
    phase_req <= 1'b0;
    repeat (2) @(posedge clock);
    chk("irq", {32'h0, irq}, 33'h1);
    rd(`RSST_ADDR_ZCAP, {17'h0, cap});
    rd(`RSST_ADDR_STATE, 33'h3);
    rd(`RSST_ADDR_STATUS, 33'h5);
    apb(1'b1, `RSST_ADDR_STATUS, 32'h5);
    repeat (2) @(posedge clock);
    chk("irq", {32'h0, irq}, 33'h0);
    rd(`RSST_ADDR_STATUS, 33'h0);
    $display("test off-time sampling done");
    d = 1 + int'(rnd() % 8);
    apb(1'b1, `RSST_ADDR_DELAY, 32'(d));
    apb(1'b1, `RSST_ADDR_CTRL, ctl(1, 3'h2, 3'h1, 1));
    comp_req <= 1'b0;
    repeat (10) @(posedge clock);
    phase_req <= 1'b1;
    wev();
    rd(`RSST_ADDR_DCAP, {17'h0, cap});
    rd(`RSST_ADDR_STATE, 33'h2);
    phase_req <= 1'b0;
    $display("test on-time delay done");
    apb(1'b1, `RSST_ADDR_CTRL, ctl(0, 3'h2, 3'h2, 1));
    repeat (10) @(posedge clock);
    comp_req <= 1'b1;
    wev();
    inr("scf delay", 3, 18);
    // clock enable low freezes the sampler: no event may show meanwhile
    comp_req <= 1'b0;
    ce <= 1'b0;
    repeat (20) begin
      @(posedge clock);
      chk("ce hold", {32'h0, zc | dm}, 33'h0);
    end
    ce <= 1'b1;
    wev();
    inr("ce resume", 3, 18);
    apb(1'b1, `RSST_ADDR_CTRL, ctl(0, 3'h2, 3'h3, 1));
    comp_req <= 1'b1;
    repeat (10) @(posedge clock);
    phase_req <= 1'b1;
    wev();
    inr("on scf delay", d + 3, d + 20);
    phase_req <= 1'b0;
    $display("test sampling clock modes done");
    apb(1'b1, `RSST_ADDR_CTRL, ctl(0, 3'h2, 3'h4, 1));
    repeat (10) @(posedge clock);
    comp_req <= 1'b0;
    wev();
    inr("tacho delay", 4, 6);
    $display("test tacho mode done");
    @(posedge clock);
    conclude();
  end
endmodule : rotor_sense_sampling_timing_bench
